// ===== src/bfs_pkg.sv
// constants and types shared by the breaker failure supervisor
// Functional notes
// - supervision timer halts as soon as breaker opening is detected
// - opening detected by current, position, or both, per selected scheme
// - opening detected while a trigger is still active enters rejected
// - rejected holds for as long as any trigger stays asserted
// - all triggers released returns the block to stand-by from rejected or tripped
// - lock output asserts in the same cycle as the backup trip
// - lock stays latched until operator acknowledge clears it
// - trigger select field picks the trip-command group used as trigger
// - three auxiliary trigger inputs can always start the supervision
// - all-commands selection: any assigned trip command starts supervision
// - external selection: only external assigned trips start supervision
// - current selection: only current-based assigned trips start supervision
// - no-assignment selection: only auxiliary inputs start supervision
// - low current with breaker off produces no pickup
// - trip delay equals supervision time from trigger to trip
// - timer keeps running after trigger drops; expiry issues backup trip
// - current scheme: failure if current not below threshold in time
// - position scheme: failure if indicators do not show open in time
// - off-nominal frequency blocks current scheme; combined acts as position
package bfs_pkg;
  // =====================================================
  // trigger selection codes
  localparam logic [1:0] BFS_TRIG_ALL  = 2'h0;
  localparam logic [1:0] BFS_TRIG_EXT  = 2'h1;
  localparam logic [1:0] BFS_TRIG_CUR  = 2'h2;
  localparam logic [1:0] BFS_TRIG_NONE = 2'h3;
  // =====================================================
  // supervision scheme codes
  localparam logic [1:0] BFS_SCH_CURRENT  = 2'h0;
  localparam logic [1:0] BFS_SCH_POSITION = 2'h1;
  localparam logic [1:0] BFS_SCH_COMBINED = 2'h2;
  // =====================================================
  // timer
  localparam int        BFS_TMR_W    = 24;
  localparam int        BFS_CLK_MHZ  = 100;
  localparam int        BFS_TICK_NS  = 1000;
  localparam int        BFS_TICK_CYC = BFS_TICK_NS * BFS_CLK_MHZ / 1000;
  localparam logic [BFS_TMR_W-1:0] BFS_TMR_RST = 24'h000000;
  // =====================================================
  // states
  typedef enum logic [1:0] {
    BFS_STANDBY  = 2'b00,
    BFS_RUNNING  = 2'b01,
    BFS_REJECTED = 2'b10,
    BFS_TRIPPED  = 2'b11
  } bfs_state_t;
endpackage

// ===== src/bfs_supervisor.sv
// breaker failure supervisor: trigger select, timer, trip and lock
`timescale 1ns/1ps
module bfs_supervisor
  import bfs_pkg::*;
#(
  parameter int TICK_CYC = BFS_TICK_CYC
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 arst_n,
  // configuration, held static
  input  wire logic [1:0]           trig_sel,
  input  wire logic [1:0]           scheme_sel,
  input  wire logic [BFS_TMR_W-1:0] failure_supervision_time,
  // trip manager inputs (asynchronous)
  input  wire logic                 external_assigned_trips,
  input  wire logic                 current_based_trips,
  input  wire logic                 other_assigned_trips,
  input  wire logic                 aux_trigger_input_a,
  input  wire logic                 aux_trigger_input_b,
  input  wire logic                 aux_trigger_input_c,
  // breaker status inputs (asynchronous)
  input  wire logic                 current_above_thr,
  input  wire logic                 pos_open,
  input  wire logic                 freq_off_nominal,
  input  wire logic                 lock_ack,
  // outputs
  output logic                      backup_trip,
  output logic                      lock_out,
  output logic [1:0]                state_out
);

  // =====================================================
  // two-stage synchronisers for every asynchronous input
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] s1_q, s2_q, s1_d, s2_d;
  always_comb begin
    s1_d = {external_assigned_trips, current_based_trips,
            other_assigned_trips, aux_trigger_input_a,
            aux_trigger_input_b, aux_trigger_input_c,
            current_above_thr, pos_open, freq_off_nominal, lock_ack};
    s2_d = s1_q;
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end
  logic ext_s, cur_s, oth_s, aa_s, ab_s, ac_s, ithr_s, open_s, foff_s;
  logic ack_s;
  assign {ext_s, cur_s, oth_s, aa_s, ab_s, ac_s,
          ithr_s, open_s, foff_s, ack_s} = s2_q;

  // =====================================================
  // trigger selection
  logic group_trig, trig_any;
  always_comb begin
    case (trig_sel)
      BFS_TRIG_ALL:  group_trig = ext_s | cur_s | oth_s;
      BFS_TRIG_EXT:  group_trig = ext_s;
      BFS_TRIG_CUR:  group_trig = cur_s;
      BFS_TRIG_NONE: group_trig = 1'b0;
      default:       group_trig = 1'b0;
    endcase
    trig_any = group_trig | aa_s | ab_s | ac_s;
  end

  // =====================================================
  // opening detection; combined needs both, off-frequency drops current
  logic opened;
  always_comb begin
    case (scheme_sel)
      BFS_SCH_CURRENT:  opened = !ithr_s && !foff_s;
      BFS_SCH_POSITION: opened = open_s;
      BFS_SCH_COMBINED: opened = foff_s ? open_s
                                        : (open_s && !ithr_s);
      default:          opened = open_s;
    endcase
  end
  // no pickup when current is low and breaker already off
  logic pickup;
  assign pickup = trig_any && !(!ithr_s && open_s);

  // =====================================================
  // prescaler tick, microsecond resolution keeps timer narrow
  logic [15:0] pre_q, pre_d;
  logic        tick;
  assign tick = (pre_q == 16'(TICK_CYC - 1));

  // =====================================================
  // state, timer, lock
  bfs_state_t            st_q, st_d;
  logic [BFS_TMR_W-1:0]  tmr_q, tmr_d;
  logic                  trip_q, trip_d, lock_q, lock_d;
  logic                  expire;
  assign expire = tick && (tmr_q + 24'h000001 >= failure_supervision_time);

  always_comb begin
    st_d   = st_q;
    tmr_d  = tmr_q;
    pre_d  = tick ? 16'h0000 : pre_q + 16'h0001;
    trip_d = 1'b0;
    lock_d = lock_q;
    case (st_q)
      BFS_STANDBY: begin
        pre_d = 16'h0000;
        tmr_d = BFS_TMR_RST;
        if (pickup) begin
          st_d = BFS_RUNNING;
        end
      end
      BFS_RUNNING: begin
        // trigger may drop, timer runs on
        if (opened) begin
          st_d = trig_any ? BFS_REJECTED : BFS_STANDBY;
        end else if (expire) begin
          st_d   = BFS_TRIPPED;
          trip_d = 1'b1;
        end else if (tick) begin
          tmr_d = tmr_q + 24'h000001;
        end
      end
      BFS_REJECTED: begin
        if (!trig_any) begin
          st_d = BFS_STANDBY;
        end
      end
      BFS_TRIPPED: begin
        trip_d = trig_any;
        if (!trig_any) begin
          st_d = BFS_STANDBY;
        end
      end
      default: st_d = BFS_STANDBY;
    endcase
    // set wins over acknowledge
    if (trip_d) begin
      lock_d = 1'b1;
    end else if (ack_s) begin
      lock_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q   <= BFS_STANDBY;
      tmr_q  <= BFS_TMR_RST;
      pre_q  <= 16'h0000;
      trip_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      tmr_q  <= tmr_d;
      pre_q  <= pre_d;
      trip_q <= trip_d;
      lock_q <= lock_d;
    end
  end

  assign backup_trip = trip_q;
  assign lock_out    = lock_q;
  assign state_out   = st_q;

  // =====================================================
  // assertions
  trip_lock_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    backup_trip |-> lock_out)
    else $error("trip without lock");
  // the clear acts one edge after the synced acknowledge
  lock_hold_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (lock_out && !ack_s) |=> lock_out)
    else $error("lock dropped without ack");
  halt_open_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (st_q == BFS_RUNNING && opened) |=> !backup_trip)
    else $error("trip after opening");
  rej_enter_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (st_q == BFS_RUNNING && opened && trig_any) |=> st_q == BFS_REJECTED)
    else $error("no rejected entry");
  rej_hold_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (st_q == BFS_REJECTED && trig_any) |=> st_q == BFS_REJECTED)
    else $error("rejected left early");
  standby_ret_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (st_q inside {BFS_REJECTED, BFS_TRIPPED} && !trig_any)
      |=> st_q == BFS_STANDBY)
    else $error("no return to standby");
  none_sel_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (st_q == BFS_STANDBY && trig_sel == BFS_TRIG_NONE
      && !aa_s && !ab_s && !ac_s) |=> st_q == BFS_STANDBY)
    else $error("group started in none mode");
  no_pickup_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (st_q == BFS_STANDBY && !ithr_s && open_s) |=> st_q == BFS_STANDBY)
    else $error("pickup with breaker off");
  // trigger drop alone must never stop a running timer
  keep_run_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (st_q == BFS_RUNNING && !opened && !expire) |=> st_q == BFS_RUNNING)
    else $error("timer stopped by trigger drop");
  cur_block_a: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (scheme_sel == BFS_SCH_CURRENT && foff_s) |-> !opened)
    else $error("current scheme not blocked");
  // cover points for the main scenarios
  cv_trip_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(backup_trip));
  cv_rej_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
    st_q == BFS_REJECTED);
  cv_ack_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
    $fell(lock_out));
  // trip issued after the trigger has already dropped
  cv_late_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(backup_trip) && !trig_any);
  cv_blk_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
    scheme_sel == BFS_SCH_CURRENT && foff_s && st_q == BFS_TRIPPED);
endmodule

// ===== testbench/bfs_breaker_model.sv
// monitored breaker model: opens a few cycles after any trip command
`timescale 1ns/1ps
module bfs_breaker_model #(
  parameter int DLY = 3
) (
  // clock
  input  wire logic       ref_clk,
  // commands from the bench
  input  wire logic       trip_cmd,
  input  wire logic [1:0] mode,
  input  wire logic       reclose,
  // breaker status seen by the supervisor
  output logic            current_above_thr,
  output logic            pos_open
);
  // ====================
  // opening mechanics
  int   cnt    = 0;
  logic opened = 1'b0;
  // opening takes DLY+1 cycles, well inside the supervision time
  always @(posedge ref_clk) begin
    if (trip_cmd && !opened) begin
      cnt <= cnt + 1;
      if (cnt >= DLY) opened <= 1'b1;
    end else begin
      cnt <= 0;
      if (!trip_cmd && reclose) opened <= 1'b0;
    end
  end
  // mode 0 healthy, 1 stuck, 2 only current drops, 3 only indicator opens
  assign current_above_thr = !(opened && (mode == 2'h0 || mode == 2'h2));
  assign pos_open          = opened && (mode == 2'h0 || mode == 2'h3);
endmodule

// ===== testbench/tb_breaker_failure_supervisor.sv
// testbench for the breaker failure supervisor
`timescale 1ns/1ps
module tb_breaker_failure_supervisor;
  import bfs_pkg::*;
  // ====================
  // stimulus and observation
  localparam int T  = 5; // far above the model's opening time
  localparam int TW = T * 2;
  logic       ref_clk    = 1'b0;
  logic       arst_n     = 1'b0;
  logic [1:0] trig_sel   = BFS_TRIG_ALL;
  logic [1:0] scheme_sel = BFS_SCH_CURRENT;
  logic [5:0] trg        = 6'h00;
  logic [1:0] mode       = 2'h0;
  logic       freq       = 1'b0;
  logic       ack        = 1'b0;
  logic       reclose    = 1'b1;
  logic       cur, opn, backup_trip, lock_out, ex;
  logic [1:0] state_out;
  int         failures   = 0;
  int         cmp_count  = 0;
  int         n;
  // scheme, breaker mode, off-nominal frequency, trip expected
  logic [5:0] tab [8] = '{6'h08, 6'h0d, 6'h1c, 6'h19, 6'h20, 6'h25, 6'h2b,
                          6'h03};
  bfs_supervisor #(.TICK_CYC(2)) DUT (
    .ref_clk(ref_clk), .arst_n(arst_n), .trig_sel(trig_sel),
    .scheme_sel(scheme_sel), .failure_supervision_time(24'(T)),
    .external_assigned_trips(trg[0]), .current_based_trips(trg[1]),
    .other_assigned_trips(trg[2]), .aux_trigger_input_a(trg[3]),
    .aux_trigger_input_b(trg[4]), .aux_trigger_input_c(trg[5]),
    .current_above_thr(cur), .pos_open(opn), .freq_off_nominal(freq),
    .lock_ack(ack), .backup_trip(backup_trip), .lock_out(lock_out),
    .state_out(state_out));
  bfs_breaker_model BRK (
    .ref_clk(ref_clk), .trip_cmd(|trg), .mode(mode), .reclose(reclose),
    .current_above_thr(cur), .pos_open(opn));
  // ====================
  // helpers
  initial forever #5 ref_clk = ~ref_clk;
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, about six times the expected run
  initial begin
    #50000;
    failures++;
    results;
  end
  // ====================
  // tests
  initial begin
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    cyc(2);
    check({backup_trip, lock_out, state_out}, 4'h0);
    // every trigger select against every source
    for (int s = 0; s < 4; s++) begin
      @(posedge ref_clk);
      trig_sel <= 2'(s);
      for (int k = 0; k < 6; k++) begin
        @(posedge ref_clk);
        trg <= 6'h01 << k;
        cyc(4);
        ex = (k > 2) || s == 0 || (s < 3 && s == k + 1);
        check(state_out, {1'b0, ex});
        @(posedge ref_clk);
        trg <= 6'h00;
        cyc(10);
        check(state_out, BFS_STANDBY);
      end
    end
    $display("test trigger select done");
    // schemes against healthy and faulty breakers
    foreach (tab[i]) begin
      @(posedge ref_clk);
      {trig_sel, scheme_sel, mode, freq} <= {BFS_TRIG_NONE, tab[i][5:1]};
      cyc(2);
      @(posedge ref_clk);
      trg <= 6'h08;
      n = 0;
      while (n < 40 && backup_trip !== 1'b1) begin
        cyc(1);
        n++;
      end
      check(n < 40, tab[i][0]);
      check(lock_out, tab[i][0]);
      if (tab[i][0]) check(n >= TW + 1 && n <= TW + 6, 1'b1);
      cyc(3);
      check(state_out, tab[i][0] ? BFS_TRIPPED : BFS_REJECTED);
      check({backup_trip, lock_out}, {2{tab[i][0]}});
      @(posedge ref_clk);
      trg <= 6'h00;
      cyc(5);
      check(state_out, BFS_STANDBY);
      check(lock_out, tab[i][0]);
      @(posedge ref_clk);
      ack <= 1'b1;
      cyc(5);
      check({backup_trip, lock_out}, 2'h0);
      @(posedge ref_clk);
      ack <= 1'b0;
    end
    $display("test schemes done");
    // trigger dropped early: the timer runs on to a one-cycle trip
    @(posedge ref_clk);
    {scheme_sel, mode, freq} <= {BFS_SCH_POSITION, 2'h1, 1'b0};
    trg <= 6'h08;
    cyc(2);
    @(posedge ref_clk);
    trg <= 6'h00;
    n = 0;
    while (n < 40 && backup_trip !== 1'b1) begin
      cyc(1);
      n++;
    end
    check(n < 40, 1'b1);
    check(lock_out, 1'b1);
    cyc(1);
    check({backup_trip, state_out}, 3'h0);
    check(lock_out, 1'b1);
    @(posedge ref_clk);
    ack <= 1'b1;
    cyc(5);
    check(lock_out, 1'b0);
    @(posedge ref_clk);
    ack <= 1'b0;
    $display("test early trigger drop done");
    // breaker left open, then triggered again: no pickup
    @(posedge ref_clk);
    {scheme_sel, mode, freq, reclose} <= {BFS_SCH_CURRENT, 4'h0};
    trg <= 6'h08;
    cyc(8);
    @(posedge ref_clk);
    trg <= 6'h00;
    cyc(6);
    @(posedge ref_clk);
    trg <= 6'h08;
    cyc(6);
    check(state_out, BFS_STANDBY);
    $display("test open breaker done");
    results;
  end
endmodule
